// ### mode_seq_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MODE_SEQ_DEFINES_SVH
`define MODE_SEQ_DEFINES_SVH
`define OFS_CONVERTER_SETUP 12'h004
`define OFS_CTRL 12'h008
`define OFS_SPOT 12'h00c
`define OFS_FILT 12'h010
`define OFS_STAT 12'h014
`define OFS_FRES 12'h018
`define OFS_DRES 12'h01c
`define CONVERTER_SETUP_RESET 32'h0000_0002
`define CONVERTER_SETUP_OVR_POL 16
`define CONVERTER_SETUP_FDMA 14
`define CONVERTER_SETUP_DDMA 13
`define CONVERTER_SETUP_PATH_LO 7
`define CONVERTER_SETUP_SEQ_LO 2
`define CONVERTER_SETUP_REPEAT 0
`define CTRL_REG_EN 5
`define CTRL_MIC_EN 3
`define CTRL_HALT 2
`define CTRL_GO 1
`define CTRL_POWER 0
`define SPOT_GO 1
`define SPOT_SRC 0
`define FILT_RATE_LO 0
`define FILT_SIDE 4
`define FILT_INTERP 5
`define FILT_HIGHF 6
`define FILT_COMB_LO 8
`define STAT_FDONE 0
`define STAT_FOVR 1
`define STAT_DDONE 2
`define CONV_CYCLES 8'd16
`define SPOT_CYCLES 8'd16
`define FILT_BASE_LAT 8'd4
`endif

// ### mode_seq_pkg.sv
// Types shared by the converter mode sequencer
package mode_seq_pkg;
   typedef enum logic [1:0] {
      PATH_RSVD,
      PATH_AUDIO,
      PATH_SEQ,
      PATH_FULL
   } path_t;
   typedef enum {
      CONV_IDLE,
      CONV_RUN,
      CONV_SPOT
   } conv_state_t;
endpackage

// ### mode_sequencer.sv
// Converter mode sequencer: mic capture, full mode and spot conversions
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "mode_seq_defines.svh"
// How it works
// - Mic mode drives divided bit clock out and samples density input.
// - Mic mode uses filter only, converts continuously into filter result.
// - Setting mic enable starts bit clock at once until cleared.
// - Filter side bit picks left or right microphone channel.
// - Interp, high-freq and comb fields set decimation ratio.
// - Each filter sample sets done flag; it lands in filter result unless an overrun under policy 0 keeps the old one.
// - First filter sample waits the filter latency for chosen ratio.
// - Filter DMA enable turns each sample into a DMA request.
// - New filter sample before prior read raises overrun flag.
// - Overrun policy 0 keeps old sample, 1 takes new one.
// - Clearing mic enable stops at once, abandoning partial sample.
// - Full mode converts external or internal sources via filter.
// - Full mode starts on go bit; results go to filter result.
// - Halt bit stops full mode at once, dropping conversion in flight.
// - Spot conversion is one battery or temperature sample via sampler.
// - Spot go launches one; result to sampler output, done flag set.
// - Spot conversion only runs alongside running audio or full mode.
// - Spot conversion forces down-sample factor to one.
// - Sampler DMA enable makes spot results into DMA requests.
// - Only sequenced+mic, audio+spot, full+spot may run together; mic capture here is not gated by path select and runs with any mode.
// - Borrowed slot repeats previous continuous result.
// - Path select 01 audio, 10 sequenced, 11 full, 00 reserved.
// - Go, halt and spot go bits self-clear once acted on.
// - Spot source 0 is battery, 1 is temperature.
module mode_sequencer
   import mode_seq_pkg::*;
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Microphone link
   output logic mic_bitclock_out,
   input wire logic mic_density_in,
   // Shared converter
   input wire logic [11:0] conv_sample,
   output logic conv_source_temp,
   output logic converter_regulator_enable,
   output logic conv_power,
   // DMA requests
   output logic filter_dma_req,
   output logic downsampler_dma_req,
   // Event lines toward the interrupt controller
   output logic filter_sample_ready,
   output logic downsampler_sample_ready
);

   // ************************************************************
   // Registers
   // ************************************************************
   logic [31:0] converter_setup_q;
   logic [5:0] ctrl_q;
   logic spot_source_select_q;
   logic [15:0] filter_setup_q;
   logic [15:0] filter_result_q;
   logic [15:0] downsampler_result_q;
   logic filter_done_flag_q;
   logic filter_overrun_flag_q;
   logic downsampler_done_flag_q;
   logic conversion_go_q;
   logic path_halt_q;
   logic spot_conversion_go_q;
   logic wr_en;
   logic rd_en;
   path_t path_select;
   logic mic_capture_enable;
   logic fres_read;
   logic dres_read;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign path_select = path_t'(converter_setup_q[`CONVERTER_SETUP_PATH_LO +: 2]);
   assign mic_capture_enable = ctrl_q[`CTRL_MIC_EN];
   assign fres_read = rd_en & (paddr == `OFS_FRES);
   assign dres_read = rd_en & (paddr == `OFS_DRES);

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_setup_q <= `CONVERTER_SETUP_RESET;
         ctrl_q <= 6'h00;
         spot_source_select_q <= 1'b0;
         filter_setup_q <= 16'h0000;
      end else if (wr_en) begin
         if (hit(paddr, `OFS_CONVERTER_SETUP)) begin
            converter_setup_q <= {11'h000, pwdata[20:11], 2'b00, pwdata[8:0]};
         end
         if (hit(paddr, `OFS_CTRL)) begin
            ctrl_q <= {pwdata[5], 1'b0, pwdata[3], 2'b00, pwdata[0]};
         end
         if (hit(paddr, `OFS_SPOT)) begin
            spot_source_select_q <= pwdata[`SPOT_SRC];
         end
         if (hit(paddr, `OFS_FILT)) begin
            filter_setup_q <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `OFS_CONVERTER_SETUP: prdata <= converter_setup_q;
               `OFS_CTRL: prdata <= {26'h0, ctrl_q[5], 1'b0, ctrl_q[3],
                  path_halt_q, conversion_go_q, ctrl_q[0]};
               `OFS_SPOT: prdata <= {30'h0, spot_conversion_go_q,
                  spot_source_select_q};
               `OFS_FILT: prdata <= {16'h0, filter_setup_q};
               `OFS_STAT: prdata <= {29'h0, downsampler_done_flag_q,
                  filter_overrun_flag_q, filter_done_flag_q};
               `OFS_FRES: prdata <= {16'h0, filter_result_q};
               `OFS_DRES: prdata <= {16'h0, downsampler_result_q};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign converter_regulator_enable = ctrl_q[`CTRL_REG_EN];
   assign conv_power = ctrl_q[`CTRL_POWER];

   // ************************************************************
   // Self-clearing command bits
   // ************************************************************
   conv_state_t conv_q;
   logic spot_done;
   logic run_done;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_go_q <= 1'b0;
         path_halt_q <= 1'b0;
         spot_conversion_go_q <= 1'b0;
      end else begin
         // Pulse commands clear the cycle after they are taken
         conversion_go_q <= wr_en & hit(paddr, `OFS_CTRL) &
            pwdata[`CTRL_GO];
         path_halt_q <= wr_en & hit(paddr, `OFS_CTRL) &
            pwdata[`CTRL_HALT];
         spot_conversion_go_q <= wr_en & hit(paddr, `OFS_SPOT) &
            pwdata[`SPOT_GO];
      end
   end

   // ************************************************************
   // Full and audio continuous runs with spot interleave
   // ************************************************************
   logic [7:0] conv_cnt_q;
   logic run_active_q;
   logic spot_pend_q;
   logic repeat_run_sel_mode;

   assign repeat_run_sel_mode = (path_select == PATH_FULL) ||
      (path_select == PATH_AUDIO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_active_q <= 1'b0;
      end else if (path_halt_q) begin
         run_active_q <= 1'b0;
      end else if (conversion_go_q && repeat_run_sel_mode) begin
         run_active_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spot_pend_q <= 1'b0;
      end else if (spot_conversion_go_q && run_active_q) begin
         spot_pend_q <= 1'b1;
      end else if (conv_q == CONV_SPOT || !run_active_q) begin
         spot_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_q <= CONV_IDLE;
         conv_cnt_q <= 8'h00;
      end else begin
         case (conv_q)
            CONV_IDLE: begin
               conv_cnt_q <= 8'h00;
               if (run_active_q) begin
                  conv_q <= CONV_RUN;
               end
            end
            CONV_RUN: begin
               if (!run_active_q) begin
                  conv_q <= CONV_IDLE;
               end else if (conv_cnt_q == `CONV_CYCLES - 8'd1) begin
                  conv_cnt_q <= 8'h00;
                  // Spot takes the next slot of the shared converter
                  conv_q <= spot_pend_q ? CONV_SPOT : CONV_RUN;
               end else begin
                  conv_cnt_q <= conv_cnt_q + 8'd1;
               end
            end
            CONV_SPOT: begin
               if (!run_active_q) begin
                  conv_q <= CONV_IDLE;
               end else if (conv_cnt_q == `SPOT_CYCLES - 8'd1) begin
                  conv_cnt_q <= 8'h00;
                  conv_q <= CONV_RUN;
               end else begin
                  conv_cnt_q <= conv_cnt_q + 8'd1;
               end
            end
            default: conv_q <= CONV_IDLE;
         endcase
      end
   end

   // A halt taken this cycle drops the slot that would end now
   assign run_done = (conv_q == CONV_RUN) && run_active_q && !path_halt_q &&
      (conv_cnt_q == `CONV_CYCLES - 8'd1);
   assign spot_done = (conv_q == CONV_SPOT) && run_active_q && !path_halt_q &&
      (conv_cnt_q == `SPOT_CYCLES - 8'd1);
   assign conv_source_temp = spot_source_select_q;

   // ************************************************************
   // Microphone link and decimation
   // ************************************************************
   logic mic_sync1_q;
   logic mic_sync2_q;
   logic [3:0] div_cnt_q;
   logic [15:0] acc_q;
   logic [15:0] dec_cnt_q;
   logic [15:0] dec_ratio;
   logic [7:0] warm_q;
   logic mic_sample;
   logic mic_take;
   logic rise;

   // Ratio only from setup fields; filter arithmetic is a plain count
   assign dec_ratio = ({8'h00, filter_setup_q[`FILT_COMB_LO +: 8]} + 16'd1)
      << {filter_setup_q[`FILT_INTERP], filter_setup_q[`FILT_HIGHF]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mic_sync1_q <= 1'b0;
         mic_sync2_q <= 1'b0;
      end else begin
         mic_sync1_q <= mic_density_in;
         mic_sync2_q <= mic_sync1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 4'h0;
         mic_bitclock_out <= 1'b0;
      end else if (!mic_capture_enable) begin
         div_cnt_q <= 4'h0;
         mic_bitclock_out <= 1'b0;
      end else if (div_cnt_q == filter_setup_q[`FILT_RATE_LO +: 4]) begin
         div_cnt_q <= 4'h0;
         mic_bitclock_out <= ~mic_bitclock_out;
      end else begin
         div_cnt_q <= div_cnt_q + 4'h1;
      end
   end

   // Left on rising edge, right on falling edge of the bit clock
   assign rise = (div_cnt_q == filter_setup_q[`FILT_RATE_LO +: 4]);
   assign mic_take = mic_capture_enable && rise &&
      (mic_bitclock_out == filter_setup_q[`FILT_SIDE]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 16'h0000;
         dec_cnt_q <= 16'h0000;
         warm_q <= 8'h00;
      end else if (!mic_capture_enable) begin
         acc_q <= 16'h0000;
         dec_cnt_q <= 16'h0000;
         warm_q <= 8'h00;
      end else if (mic_take) begin
         if (dec_cnt_q == dec_ratio - 16'd1) begin
            dec_cnt_q <= 16'h0000;
            acc_q <= 16'h0000;
            if (warm_q != `FILT_BASE_LAT) begin
               warm_q <= warm_q + 8'd1;
            end
         end else begin
            dec_cnt_q <= dec_cnt_q + 16'd1;
            acc_q <= acc_q + {15'h0000, mic_sync2_q};
         end
      end
   end

   assign mic_sample = mic_take && (dec_cnt_q == dec_ratio - 16'd1) &&
      (warm_q == `FILT_BASE_LAT);

   // ************************************************************
   // Result registers, flags and requests
   // ************************************************************
   logic f_new;
   logic [15:0] f_val;
   assign f_new = mic_sample | run_done;
   assign f_val = mic_sample ? acc_q + {15'h0000, mic_sync2_q} :
      {4'h0, conv_sample};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_result_q <= 16'h0000;
      end else if (f_new && (!filter_done_flag_q ||
            converter_setup_q[`CONVERTER_SETUP_OVR_POL])) begin
         filter_result_q <= f_val;
      end else if (spot_done) begin
         filter_result_q <= filter_result_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_done_flag_q <= 1'b0;
         filter_overrun_flag_q <= 1'b0;
      end else begin
         // Set wins over a read that clears in the same cycle
         filter_done_flag_q <= f_new | (filter_done_flag_q & ~fres_read);
         filter_overrun_flag_q <= (f_new & filter_done_flag_q & ~fres_read) |
            (filter_overrun_flag_q & ~(wr_en & hit(paddr, `OFS_STAT) &
            pwdata[`STAT_FOVR]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         downsampler_result_q <= 16'h0000;
         downsampler_done_flag_q <= 1'b0;
      end else begin
         if (spot_done) begin
            // Factor forced to one: raw sample, no accumulation
            downsampler_result_q <= {4'h0, conv_sample};
         end
         downsampler_done_flag_q <= spot_done |
            (downsampler_done_flag_q & ~dres_read);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filter_dma_req <= 1'b0;
         filter_sample_ready <= 1'b0;
         downsampler_dma_req <= 1'b0;
         downsampler_sample_ready <= 1'b0;
      end else begin
         filter_dma_req <= f_new & converter_setup_q[`CONVERTER_SETUP_FDMA];
         filter_sample_ready <= f_new & ~converter_setup_q[`CONVERTER_SETUP_FDMA];
         downsampler_dma_req <= spot_done & converter_setup_q[`CONVERTER_SETUP_DDMA];
         downsampler_sample_ready <= spot_done &
            ~converter_setup_q[`CONVERTER_SETUP_DDMA];
      end
   end

endmodule

// ### mode_seq_properties.sv
// Port-level checks for the mode sequencer
`timescale 1ns/1ps
`include "mode_seq_defines.svh"
module mode_seq_properties (
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Watched outputs
   input wire logic mic_bitclock_out,
   input wire logic conv_source_temp,
   input wire logic filter_dma_req,
   input wire logic downsampler_dma_req,
   input wire logic filter_sample_ready,
   input wire logic downsampler_sample_ready
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr, w_ctrl, chg, fdma_q, ddma_q, en_q, seen_q, last_q, run_q;
   logic [1:0] path_q;
   logic [3:0] rate_q, cnt_q;
   assign wr = psel && penable && pwrite;
   assign w_ctrl = wr && paddr == `OFS_CTRL;
   assign chg = mic_bitclock_out != last_q;
   // ****************************************
   // Shadow of the bus writes
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {fdma_q, ddma_q, en_q, seen_q, last_q, run_q} <= '0;
         path_q <= '0;
         rate_q <= '0;
         cnt_q <= '0;
      end else begin
         last_q <= mic_bitclock_out;
         cnt_q <= chg ? 4'h0 : cnt_q + 4'h1;
         // First toggle after enable has no reference point
         seen_q <= en_q && (seen_q || chg);
         if (wr && paddr == `OFS_CONVERTER_SETUP) begin
            fdma_q <= pwdata[`CONVERTER_SETUP_FDMA];
            ddma_q <= pwdata[`CONVERTER_SETUP_DDMA];
            path_q <= pwdata[`CONVERTER_SETUP_PATH_LO +: 2];
         end
         if (wr && paddr == `OFS_FILT) begin
            rate_q <= pwdata[3:0];
         end
         if (w_ctrl) begin
            en_q <= pwdata[`CTRL_MIC_EN];
            if (pwdata[`CTRL_HALT]) begin
               run_q <= 1'b0;
            end else if (pwdata[`CTRL_GO] && path_q[0]) begin
               run_q <= 1'b1;
            end
         end
      end
   end
   a_mic_start: assert property (p_mic_start) else $error("no bit clock");
   property p_mic_start;
      w_ctrl && pwdata[`CTRL_MIC_EN] && !en_q |-> ##[1:20] mic_bitclock_out;
   endproperty
   a_mic_idle: assert property (p_mic_idle) else $error("clock not idle");
   property p_mic_idle;
      !en_q && !$past(en_q) |-> !mic_bitclock_out;
   endproperty
   a_clk_period: assert property (p_clk_period) else $error("bad period");
   property p_clk_period;
      chg && seen_q && en_q |-> cnt_q == rate_q;
   endproperty
   a_src: assert property (p_src) else $error("wrong spot source");
   property p_src;
      wr && paddr == `OFS_SPOT |=> conv_source_temp == $past(pwdata[0]);
   endproperty
   a_halt: assert property (p_halt) else $error("result after halt");
   property p_halt;
      w_ctrl && pwdata[`CTRL_HALT] |=>
         ##1 (!filter_sample_ready && !filter_dma_req) [*8];
   endproperty
   a_spot_run: assert property (p_spot_run) else $error("lone spot");
   property p_spot_run;
      downsampler_sample_ready || downsampler_dma_req |-> $past(run_q);
   endproperty
   a_fdma: assert property (p_fdma) else $error("filter dma route");
   property p_fdma;
      filter_dma_req |-> $past(fdma_q) && !filter_sample_ready;
   endproperty
   a_fsr: assert property (p_fsr) else $error("filter event route");
   property p_fsr;
      filter_sample_ready |-> !$past(fdma_q);
   endproperty
   a_ddma: assert property (p_ddma) else $error("spot dma route");
   property p_ddma;
      downsampler_dma_req |-> $past(ddma_q) && !downsampler_sample_ready;
   endproperty
endmodule
bind mode_sequencer mode_seq_properties mode_seq_properties_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .mic_bitclock_out(mic_bitclock_out), .conv_source_temp(conv_source_temp),
   .filter_dma_req(filter_dma_req), .downsampler_dma_req(downsampler_dma_req),
   .filter_sample_ready(filter_sample_ready),
   .downsampler_sample_ready(downsampler_sample_ready));

// ### mic_model.sv
// Microphone on the pulse-density link
`timescale 1ns/1ps
module mic_model (
   // Clock and link
   input wire logic pclk,
   input wire logic mic_bitclock_out,
   output logic mic_density_in,
   // Channel levels
   input wire logic left_bit,
   input wire logic right_bit
);
   logic last_q = 1'b0;
   int idle_q = 0;
   initial mic_density_in = 1'b0;
   always @(posedge pclk) begin
      last_q <= mic_bitclock_out;
      if (mic_bitclock_out !== last_q) begin
         idle_q <= 0;
         mic_density_in <= mic_bitclock_out ? left_bit : right_bit;
      end else if (idle_q > 8) begin
         // Released line, so no stale level
         mic_density_in <= ~mic_density_in;
      end else begin
         idle_q <= idle_q + 1;
      end
   end
endmodule

// ### mode_sequencer_tb_top.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
`include "mode_seq_defines.svh"
module mode_sequencer_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, left_bit = 1'b1, right_bit = 1'b0;
   logic [11:0] paddr = '0, conv_sample = '0;
   logic [31:0] pwdata = '0, last_rd = '0, prdata;
   logic pready, mic_bitclock_out, mic_density_in, conv_source_temp;
   logic filter_dma_req, downsampler_dma_req;
   logic pslverr, converter_regulator_enable, conv_power;
   logic filter_sample_ready, downsampler_sample_ready;
   int errors = 0, n_tests = 0, nf = 0, nd = 0, nfd = 0, ndd = 0;
   int cyc = 0, n0, d0, c;
   logic [11:0] aq[$];
   logic [31:0] eq[$], mq[$], res[2];
   always #5 pclk = ~pclk;
   mode_sequencer mode_sequencer_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .mic_bitclock_out(mic_bitclock_out),
      .mic_density_in(mic_density_in), .conv_sample(conv_sample),
      .conv_source_temp(conv_source_temp),
      .converter_regulator_enable(converter_regulator_enable),
      .conv_power(conv_power), .filter_dma_req(filter_dma_req),
      .downsampler_dma_req(downsampler_dma_req),
      .filter_sample_ready(filter_sample_ready),
      .downsampler_sample_ready(downsampler_sample_ready));
   mic_model mic_model_i (.pclk(pclk), .mic_bitclock_out(mic_bitclock_out),
      .mic_density_in(mic_density_in), .left_bit(left_bit),
      .right_bit(right_bit));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic complete_run();
      $display("errors %0d n_tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
      aq.push_back(a);
      eq.push_back(e & m);
      mq.push_back(m);
      apb(1'b0, a, '0);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // ****************************************
   // Monitor, counts and timeout
   // ****************************************
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      nf <= nf + int'(filter_sample_ready === 1'b1);
      nd <= nd + int'(downsampler_sample_ready === 1'b1);
      nfd <= nfd + int'(filter_dma_req === 1'b1);
      ndd <= ndd + int'(downsampler_dma_req === 1'b1);
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         last_rd <= prdata;
         check("slverr", 32'(pslverr), 32'h0);
         check($sformatf("read %h", aq.pop_front()),
            prdata & mq.pop_front(), eq.pop_front());
      end
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      void'($urandom(32'hfa0dbde6));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`OFS_CONVERTER_SETUP, `CONVERTER_SETUP_RESET, '1);
      rd(12'h020, 32'h0, '1);
      for (int p = 0; p < 4; p++) begin
         conv_sample <= 12'($urandom);
         apb(1'b1, `OFS_CONVERTER_SETUP, (32'(p) << `CONVERTER_SETUP_PATH_LO) | 32'h1);
         apb(1'b1, `OFS_CTRL, 32'h23);
         rd(`OFS_CTRL, 32'h21, '1);
         n0 = nf;
         d0 = nd;
         wt(40);
         apb(1'b1, `OFS_SPOT, 32'h2 | 32'(p % 2));
         wt(40);
         check("source pin", 32'(conv_source_temp), 32'(p % 2));
         check("power pins", 32'({converter_regulator_enable, conv_power}),
            32'h3);
         check("filter run", 32'(nf > n0), 32'(p % 2));
         check("spot run", 32'(nd - d0), 32'(p % 2));
         if (p % 2) begin
            rd(`OFS_STAT, 32'h4, 32'h4);
            rd(`OFS_DRES, {20'h0, conv_sample}, '1);
         end
         apb(1'b1, `OFS_CTRL, 32'h25);
         // A slot ending just before the halt still reports
         wt(2);
         n0 = nf;
         wt(1000);
         check("halted", 32'(nf - n0), 0);
      end
      apb(1'b1, `OFS_CONVERTER_SETUP, 32'h6181);
      // Clear the done flag so the first run result is kept
      rd(`OFS_FRES, '0, '0);
      n0 = nfd;
      d0 = ndd;
      apb(1'b1, `OFS_CTRL, 32'h23);
      wt(40);
      res[0] = 32'(conv_sample);
      conv_sample <= 12'($urandom);
      apb(1'b1, `OFS_SPOT, 32'h2);
      wt(40);
      check("filter dma", 32'(nfd > n0), 1);
      check("spot dma", 32'(ndd - d0), 1);
      rd(`OFS_FRES, res[0], '1);
      apb(1'b1, `OFS_CONVERTER_SETUP, 32'h0001_6181);
      wt(20);
      conv_sample <= 12'($urandom);
      wt(40);
      rd(`OFS_FRES, {20'h0, conv_sample}, '1);
      apb(1'b1, `OFS_CTRL, 32'h25);
      wt(1000);
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, `OFS_CONVERTER_SETUP, 32'h100);
         // Rate 3 gives an 80 ns link clock
         apb(1'b1, `OFS_FILT, 32'h0303 | (32'(s) << `FILT_SIDE));
         rd(`OFS_FRES, '0, '0);
         n0 = nf;
         c = 0;
         apb(1'b1, `OFS_CTRL, 32'h8);
         while (nf == n0 && c < 400) begin
            @(posedge pclk);
            c++;
         end
         check("warm-up", 32'(c >= 128 && c < 400), 1);
         wt(100);
         rd(`OFS_STAT, 32'h3, 32'h3);
         rd(`OFS_FRES, '0, '0);
         res[s] = last_rd;
         apb(1'b1, `OFS_CTRL, 32'h0);
         wt(2);
         n0 = nf;
         wt(60);
         check("mic stop", 32'(nf - n0), 0);
         check("clock idle", 32'(mic_bitclock_out), 0);
         apb(1'b1, `OFS_STAT, 32'h2);
      end
      check("side", 32'(res[0] !== res[1]), 1);
      complete_run();
   end
endmodule
